// [core/skp_map.svh]
// Constants for the SKP scheduler, elasticity buffer and compliance sequencer.
`ifndef SKP_MAP_SVH
`define SKP_MAP_SVH

// ----------------------------------------------------------------------------
// Symbol codes
// ----------------------------------------------------------------------------
`define SYM_K_SKP 8'h3C
`define SYM_K_COM 8'hBC
`define SYM_K_287 8'hFC
`define SYM_D_10_2 8'h4A
`define SYM_D_24_3 8'h78
`define SYM_D_0_0 8'h00
`define SYM_D_5_2 8'h45
`define SYM_ONES 8'hFF

// ----------------------------------------------------------------------------
// Scheduling and buffer sizes
// ----------------------------------------------------------------------------
`define SKP_INTERVAL 9'h162
`define SKP_MAX_PEND 3'h4
`define SKP_TRAIN_MIN 3'h2
`define EB_DEPTH 5'h10
`define EB_NOMINAL 5'h08
`define TS_ID_IDX 4'h6
`define TS_LAST_IDX 4'hF
`define CP_RUN_SYMS 4'hA

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_NS 40
`define LINK_SYM_NS 320
`define SYM_DIV (`LINK_SYM_NS / `MCLK_NS)

`endif

// [core/skp_pkg.sv]
// Types shared by the SKP scheduler, elasticity buffer and compliance sequencer.
package skp_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } sym_t;

  typedef struct packed {
    sym_t sym;
    logic last;
  } tx_word_t;

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  typedef enum logic [9:0] {
    CP_OFF = 10'h001, CP_0 = 10'h002, CP_1 = 10'h004, CP_2 = 10'h008, CP_3 = 10'h010,
    CP_4   = 10'h020, CP_5 = 10'h040, CP_6 = 10'h080, CP_7 = 10'h100, CP_8 = 10'h200
  } cp_t;

  typedef enum logic [1:0] {
    TX_DATA = 2'h1,
    TX_SKP  = 2'h2
  } tx_st_t;

endpackage : skp_pkg

// [core/link_sync.sv]
// Three-stage synchroniser for the link clock and receive symbol pins.
`timescale 1ns/1ps
module link_sync (
  // Clock and control.
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Asynchronous pins and synchronised stages.
  input  wire logic [9:0] d,
  output logic      [9:0] s2,
  output logic      [9:0] s3
);

  // --------------------------------------------------------------------------
  // Per-bit flop chains
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // The first stage feeds only the second stage.
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= d[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      assign s2[gi] = s2_reg;
      assign s3[gi] = s3_reg;
    end
  endgenerate

endmodule : link_sync

// [core/skid2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module skid2 (
  // Clock and control.
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Filling side.
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire skp_pkg::sym_t in_data,
  // Draining side.
  output logic             out_valid,
  input  wire logic        out_ready,
  output skp_pkg::sym_t    out_data
);
  import skp_pkg::*;

  sym_t       mem_reg [2];
  logic       wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] cnt_reg, cnt_next;
  logic       push, pop;

  // Handshakes follow the entry count directly.
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Pointer and count update.
  always_comb begin
    wp_next  = push ? ~wp_reg : wp_reg;
    rp_next  = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  // Registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (ce) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      if (push) begin
        mem_reg[wp_reg] <= in_data;
      end
    end
  end

endmodule : skid2

// [core/skp_scheduler_elastic_compliance.sv]
// SKP scheduler, receive elasticity buffer and compliance pattern sequencer.
`timescale 1ns/1ps
`include "skp_map.svh"

// What this block does
// - absorb -5300 to +300 ppm offset via SKP
// - transmit one SKP set per 354 symbols
// - never place SKP inside a packet
// - hold at most four pending SKP sets
// - elastic buffer absorbs eight symbols either way
// - SKP set is two K28.1 symbols
// - symbol counter clears entering Polling.Active
// - insert quotient of count/354 after units
// - training may defer until two pending
// - SKP only at allowed insertion points
// - keep the remainder of count/354
// - SKP does not break TS run count
// - CP0 is scrambled D0.0 without SKP
// - no SKP during compliance patterns
// - ping LFPS advances CP0 through CP8
// - reset LFPS ends compliance patterns
// - CP4 is LFPS, not symbols
// - CP7/CP8 bit runs, de-emphasis differs
// - compliance patterns unscrambled unless stated
// - never split a TS1 or TS2 set
// - no SKP during TSEQ
module skp_scheduler_elastic_compliance (
  // Clock, reset and clock enable.
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Transmit symbols from the link layer.
  input  wire logic              tx_in_valid,
  output logic                   tx_in_ready,
  input  wire skp_pkg::tx_word_t tx_in,
  // Training and compliance control.
  input  wire logic              training,
  input  wire logic              polling_active,
  input  wire logic              tseq_active,
  input  wire logic              compliance_start,
  input  wire logic              ping_lfps,
  input  wire logic              reset_lfps,
  // Transmit symbols to the serialiser.
  output logic                   tx_out_valid,
  input  wire logic              tx_out_ready,
  output skp_pkg::sym_t          tx_out,
  output logic                   tx_scramble,
  output logic                   tx_deemph,
  output logic                   tx_raw,
  output logic                   tx_lfps_en,
  // Receive pins on the recovered clock.
  input  wire logic              rx_clk,
  input  wire skp_pkg::sym_t     rx_sym,
  // Receive symbols to the link layer.
  output logic                   rx_out_valid,
  input  wire logic              rx_out_ready,
  output skp_pkg::sym_t          rx_out,
  output logic                   eb_over,
  output logic                   eb_under,
  output logic [7:0]             ts_count,
  output logic [1:0]             ts_kind
);
  import skp_pkg::*;

  localparam logic [3:0] SYM_DIV_C = 4'(`SYM_DIV);

  // --------------------------------------------------------------------------
  // Transmit scheduler
  // --------------------------------------------------------------------------
  tx_st_t   st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [2:0] pend_reg, pend_next;
  logic     half_reg, half_next;
  logic     out_v_reg, out_v_next;
  sym_t     out_reg, out_next;
  logic     adv, take, cp_on;
  cp_t      cp_reg, cp_next;
  logic [3:0] run_reg, run_next;
  logic     ph_reg, ph_next;

  assign adv         = ce && (!out_v_reg || tx_out_ready);
  assign cp_on       = (cp_reg != CP_OFF);
  assign tx_in_ready = adv && (st_reg == TX_DATA) && !cp_on;
  assign take        = tx_in_valid && tx_in_ready;
  assign tx_out_valid = out_v_reg;
  assign tx_out       = out_reg;

  // Symbol count, pending SKP sets and output symbol selection.
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    half_next  = half_reg;
    out_v_next = out_v_reg;
    out_next   = out_reg;
    if (take) begin
      // Whole intervals become pending sets; the remainder stays in the count.
      if (cnt_reg == `SKP_INTERVAL - 9'h001) begin
        cnt_next = 9'h000;
        if (pend_reg != `SKP_MAX_PEND) begin
          pend_next = pend_reg + 3'h1;
        end
      end else begin
        cnt_next = cnt_reg + 9'h001;
      end
    end
    if (adv) begin
      out_v_next = 1'b0;
      if (cp_on) begin
        out_v_next = (cp_reg != CP_4);
        out_next   = cp_sym(cp_reg, ph_reg);
      end else if (st_reg == TX_SKP) begin
        // Two K28.1 symbols per set, then the next set or back to data.
        out_v_next = 1'b1;
        out_next   = '{k: 1'b1, d: `SYM_K_SKP};
        half_next  = ~half_reg;
        if (half_reg) begin
          pend_next = pend_reg - 3'h1;
          if (pend_reg == 3'h1) begin
            st_next = TX_DATA;
          end
        end
      end else if (take) begin
        out_v_next = 1'b1;
        out_next   = tx_in.sym;
        // Insert only after a complete unit, never in TSEQ, deferred in training.
        if (tx_in.last && pend_next != 3'h0 && !tseq_active &&
            (!training || pend_next >= `SKP_TRAIN_MIN)) begin
          st_next   = TX_SKP;
          half_next = 1'b0;
        end
      end
    end
    if (polling_active) begin
      cnt_next  = 9'h000;
      pend_next = 3'h0;
      st_next   = TX_DATA;
    end
    if (cp_on) begin
      st_next = TX_DATA;
    end
  end

  // Scheduler registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg    <= TX_DATA;
      cnt_reg   <= 9'h000;
      pend_reg  <= 3'h0;
      half_reg  <= 1'b0;
      out_v_reg <= 1'b0;
      out_reg   <= '0;
    end else if (ce) begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      half_reg  <= half_next;
      out_v_reg <= out_v_next;
      out_reg   <= out_next;
    end
  end

  // --------------------------------------------------------------------------
  // Compliance sequencer
  // --------------------------------------------------------------------------
  // Pattern symbol for each compliance state.
  function automatic sym_t cp_sym(input cp_t c, input logic ph);
    sym_t s;
    s = '{k: 1'b0, d: `SYM_D_0_0};
    case (c)
      CP_1: s.d = `SYM_D_10_2;
      CP_2: s.d = `SYM_D_24_3;
      CP_3: s = '{k: 1'b1, d: `SYM_K_COM};
      CP_5, CP_6: s = '{k: 1'b1, d: `SYM_K_287};
      CP_7, CP_8: s.d = ph ? `SYM_D_0_0 : `SYM_ONES;
      default: s = s;
    endcase
    return s;
  endfunction : cp_sym

  // Pattern advance on ping, stop on reset, bit-run phase for CP7 and CP8.
  always_comb begin
    cp_next  = cp_reg;
    run_next = run_reg;
    ph_next  = ph_reg;
    if (reset_lfps) begin
      cp_next = CP_OFF;
    end else if (compliance_start && !cp_on) begin
      cp_next = CP_0;
    end else if (ping_lfps) begin
      case (cp_reg)
        CP_0: cp_next = CP_1;
        CP_1: cp_next = CP_2;
        CP_2: cp_next = CP_3;
        CP_3: cp_next = CP_4;
        CP_4: cp_next = CP_5;
        CP_5: cp_next = CP_6;
        CP_6: cp_next = CP_7;
        CP_7: cp_next = CP_8;
        CP_8: cp_next = CP_0;
        default: cp_next = cp_reg;
      endcase
    end
    if (adv && (cp_reg == CP_7 || cp_reg == CP_8)) begin
      if (run_reg == `CP_RUN_SYMS - 4'h1) begin
        run_next = 4'h0;
        ph_next  = ~ph_reg;
      end else begin
        run_next = run_reg + 4'h1;
      end
    end
  end

  // Sequencer registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cp_reg  <= CP_OFF;
      run_reg <= 4'h0;
      ph_reg  <= 1'b0;
    end else if (ce) begin
      cp_reg  <= cp_next;
      run_reg <= run_next;
      ph_reg  <= ph_next;
    end
  end

  // Line controls for the serialiser.
  assign tx_scramble = (cp_reg == CP_0);
  assign tx_deemph   = (cp_reg == CP_5) || (cp_reg == CP_7);
  assign tx_raw      = (cp_reg == CP_7) || (cp_reg == CP_8);
  assign tx_lfps_en  = (cp_reg == CP_4);

  // --------------------------------------------------------------------------
  // Receive elasticity buffer
  // --------------------------------------------------------------------------
  logic [9:0] s2, s3;
  logic       lvl_reg, lvl_next, rx_edge;
  sym_t       in_s, rd_s;
  sym_t       eb_reg [16];
  logic [3:0] wp_reg, wp_next, rp_reg, rp_next, tick_reg, tick_next;
  logic [4:0] fill_reg, fill_next;
  logic       run_on_reg, run_on_next, dup_reg, dup_next;
  logic       wr, rd, tick, sk_ready;
  logic       ov_reg, ov_next, un_reg, un_next;

  link_sync u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({rx_clk, rx_sym}),
    .s2   (s2),
    .s3   (s3)
  );

  assign in_s    = s3[8:0];
  assign rx_edge = (s2[9] == s3[9]) && s3[9] && !lvl_reg;
  assign tick    = (tick_reg == SYM_DIV_C - 4'h1);
  assign rd_s    = eb_reg[rp_reg];
  // Excess SKP symbols are not written while the buffer is above nominal.
  assign wr      = rx_edge && (fill_reg != `EB_DEPTH) &&
                   !(in_s.k && in_s.d == `SYM_K_SKP && fill_reg > `EB_NOMINAL);
  assign rd      = tick && run_on_reg && sk_ready && (fill_reg != 5'h00);

  // Fill tracking with SKP duplication when below nominal.
  always_comb begin
    lvl_next    = (s2[9] == s3[9]) ? s3[9] : lvl_reg;
    tick_next   = tick ? 4'h0 : tick_reg + 4'h1;
    wp_next     = wr ? wp_reg + 4'h1 : wp_reg;
    rp_next     = rp_reg;
    dup_next    = dup_reg;
    fill_next   = fill_reg + {4'h0, wr};
    run_on_next = run_on_reg || (fill_reg >= `EB_NOMINAL);
    ov_next     = rx_edge && (fill_reg == `EB_DEPTH);
    un_next     = tick && run_on_reg && sk_ready && (fill_reg == 5'h00);
    if (rd) begin
      if (rd_s.k && rd_s.d == `SYM_K_SKP && fill_reg < `EB_NOMINAL && !dup_reg) begin
        dup_next = 1'b1;
      end else begin
        rp_next   = rp_reg + 4'h1;
        dup_next  = 1'b0;
        fill_next = fill_reg + {4'h0, wr} - 5'h01;
      end
    end
  end

  // Buffer registers; storage is indexed by the write pointer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_reg    <= 1'b0;
      tick_reg   <= 4'h0;
      wp_reg     <= 4'h0;
      rp_reg     <= 4'h0;
      fill_reg   <= 5'h00;
      dup_reg    <= 1'b0;
      run_on_reg <= 1'b0;
      ov_reg     <= 1'b0;
      un_reg     <= 1'b0;
      eb_reg     <= '{default: '0};
    end else if (ce) begin
      lvl_reg    <= lvl_next;
      tick_reg   <= tick_next;
      wp_reg     <= wp_next;
      rp_reg     <= rp_next;
      fill_reg   <= fill_next;
      dup_reg    <= dup_next;
      run_on_reg <= run_on_next;
      ov_reg     <= ov_next;
      un_reg     <= un_next;
      if (wr) begin
        eb_reg[wp_reg] <= in_s;
      end
    end
  end

  assign eb_over  = ov_reg;
  assign eb_under = un_reg;

  skid2 u_skid (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (rd),
    .in_ready  (sk_ready),
    .in_data   (rd_s),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out)
  );

  // --------------------------------------------------------------------------
  // Training set run counter
  // --------------------------------------------------------------------------
  logic [3:0] idx_reg, idx_next;
  logic [7:0] tc_reg, tc_next;
  logic [1:0] tk_reg, tk_next, kind;

  // SKP symbols leave the set index and the run count untouched.
  always_comb begin
    idx_next = idx_reg;
    tc_next  = tc_reg;
    tk_next  = tk_reg;
    kind     = (rd_s.d == `SYM_D_10_2) ? 2'h1 : (rd_s.d == `SYM_D_5_2) ? 2'h2 : 2'h0;
    if (rd && !(rd_s.k && rd_s.d == `SYM_K_SKP)) begin
      if (rd_s.k && rd_s.d == `SYM_K_COM && (idx_reg == 4'h0 || idx_reg >= `TS_ID_IDX)) begin
        idx_next = 4'h1;
      end else if (idx_reg != `TS_LAST_IDX) begin
        idx_next = idx_reg + 4'h1;
      end
      if (idx_reg == `TS_ID_IDX) begin
        tk_next = kind;
        if (kind == 2'h0) begin
          tc_next = 8'h00;
        end else if (kind != tk_reg) begin
          tc_next = 8'h01;
        end else if (tc_reg != 8'hFF) begin
          tc_next = tc_reg + 8'h01;
        end
      end
    end
  end

  // Run counter registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idx_reg <= 4'h0;
      tc_reg  <= 8'h00;
      tk_reg  <= 2'h0;
    end else if (ce) begin
      idx_reg <= idx_next;
      tc_reg  <= tc_next;
      tk_reg  <= tk_next;
    end
  end

  assign ts_count = tc_reg;
  assign ts_kind  = tk_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_pend_cap: assert property (pend_reg <= `SKP_MAX_PEND) else $error("pending SKP above four");
  a_count_rem: assert property (cnt_reg < `SKP_INTERVAL) else $error("symbol count overran");
  a_poll_clear: assert property (ce && polling_active |=> cnt_reg == 9'h000)
    else $error("count not cleared");
  a_cp_no_skp: assert property (cp_on && ce |=> !(st_reg == TX_SKP)) else $error("SKP in compliance");
  a_tseq_skp: assert property (ce && st_reg == TX_DATA && tseq_active |=> st_reg == TX_DATA)
    else $error("SKP during TSEQ");
  a_skp_boundary: assert property (ce && $rose(st_reg == TX_SKP) |-> $past(take && tx_in.last))
    else $error("SKP not at unit end");
  a_skp_pair: assert property (adv && st_reg == TX_SKP && !half_reg |=> out_reg.d == `SYM_K_SKP ##0
    st_reg == TX_SKP) else $error("SKP set split");
  a_ping_adv: assert property (ce && cp_reg == CP_0 && ping_lfps && !reset_lfps |=> cp_reg == CP_1)
    else $error("ping did not advance");
  a_reset_stop: assert property (ce && reset_lfps |=> cp_reg == CP_OFF) else $error("reset LFPS ignored");
  a_cp4_lfps: assert property (cp_reg == CP_4 ##1 cp_reg == CP_4 |-> tx_lfps_en && !tx_out_valid)
    else $error("CP4 sent symbols");
  a_eb_fill: assert property (fill_reg <= `EB_DEPTH) else $error("buffer fill overran");

endmodule : skp_scheduler_elastic_compliance

// [sim/link_partner.sv]
// Far-side port model: recovered symbol clock and receive symbols.
`timescale 1ns/1ps
`include "skp_map.svh"
module link_partner #(
  parameter int HALF_NS = 160,
  parameter int SKP_GAP = 6
) (
  // Frame control from the bench.
  input  wire logic     en,
  input  wire logic     ts_on,
  // Lane toward the receiver.
  output logic          rx_clk,
  output skp_pkg::sym_t rx_sym
);
  import skp_pkg::*;
  logic [7:0] data_n;
  int         slot;

  // --------------------------------------------------------------------------
  // Symbol source
  // --------------------------------------------------------------------------
  // Symbols change at the falling edge so they are settled around the rising edge.
  // Outside frames the clock stands still and the lane toggles, so no stale symbol is seen.
  initial begin
    rx_clk = 1'b0;
    rx_sym = '0;
    data_n = 8'h00;
    slot   = 0;
    #7;
    forever begin
      if (en !== 1'b1) begin
        rx_clk = 1'b0;
        rx_sym = ~rx_sym;
        #(HALF_NS);
      end else begin
        if (ts_on === 1'b1) begin
          // Sixteen-symbol training sets, each preceded by one SKP set, never split.
          rx_sym = (slot % 18 < 2) ? {1'b1, `SYM_K_SKP} : (slot % 18 < 6) ? {1'b1, `SYM_K_COM} :
                   (slot % 18 < 8) ? 9'h000 : {1'b0, `SYM_D_10_2};
        end else if (slot % SKP_GAP < 2) begin
          rx_sym = {1'b1, `SYM_K_SKP};
        end else begin
          rx_sym = {1'b0, data_n};
          data_n = data_n + 8'h01;
        end
        slot = slot + 1;
        #(HALF_NS);
        rx_clk = 1'b1;
        #(HALF_NS);
        rx_clk = 1'b0;
      end
    end
  end
endmodule : link_partner

// [sim/skp_scheduler_elastic_compliance_bench.sv]
// Self-checking bench for the SKP scheduler, elasticity buffer and pattern sequencer.
`timescale 1ns/1ps
`include "skp_map.svh"
module skp_scheduler_elastic_compliance_bench;
  import skp_pkg::*;
  typedef struct packed { logic [3:0] fl; logic chk; sym_t s; } cp_row_t;
  logic       mclk, rst, training, polling_active, tseq_active, compliance_start, ping_lfps;
  logic       reset_lfps, tx_in_valid, tx_in_ready, tx_out_valid, tx_scramble, tx_deemph, tx_raw;
  logic       tx_lfps_en, rx_clk, rx_out_valid, rx_out_ready, eb_over, eb_under, link_en, after_last, ts_on;
  logic [7:0] ts_count, rx_prev;
  logic [1:0] ts_kind;
  tx_word_t   tx_in;
  sym_t       tx_out, rx_sym, rx_out;
  int         n_fail, cmp_count, cyc, skp_n, run_n, bad_n, over_n, have_prev;
  cp_row_t    rows [9];

  skp_scheduler_elastic_compliance dut (.mclk(mclk), .rst(rst), .ce(1'b1), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in(tx_in), .training(training), .polling_active(polling_active),
    .tseq_active(tseq_active), .compliance_start(compliance_start), .ping_lfps(ping_lfps),
    .reset_lfps(reset_lfps), .tx_out_valid(tx_out_valid), .tx_out_ready(1'b1), .tx_out(tx_out),
    .tx_scramble(tx_scramble), .tx_deemph(tx_deemph), .tx_raw(tx_raw), .tx_lfps_en(tx_lfps_en),
    .rx_clk(rx_clk), .rx_sym(rx_sym), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .rx_out(rx_out), .eb_over(eb_over), .eb_under(eb_under), .ts_count(ts_count), .ts_kind(ts_kind));
  link_partner partner (.en(link_en), .ts_on(ts_on), .rx_clk(rx_clk), .rx_sym(rx_sym));

  // The clock runs at 25 MHz.
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  // Compares one value and reports a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Pulses {polling_active, compliance_start, ping_lfps, reset_lfps} for one cycle.
  task automatic ctl(input logic [3:0] v);
    @(negedge mclk);
    {polling_active, compliance_start, ping_lfps, reset_lfps} = v;
    @(negedge mclk);
    {polling_active, compliance_start, ping_lfps, reset_lfps} = 4'h0;
  endtask : ctl

  // Sends back-to-back 16-symbol units; the marker EE ends each unit, then drains.
  task automatic send(input int units);
    int i;
    i = 0;
    while (i < units * 16) begin
      @(negedge mclk);
      tx_in_valid = 1'b1;
      tx_in = {1'b0, (i % 16 == 15) ? 8'hEE : 8'h11, i % 16 == 15};
      #1;
      if (tx_in_ready === 1'b1) i++;
    end
    @(negedge mclk);
    tx_in_valid = 1'b0;
    repeat (16) @(negedge mclk);
  endtask : send

  // --------------------------------------------------------------------------
  // Monitors
  // --------------------------------------------------------------------------
  // Watches SKP placement, receive order, overflow and the cycle ceiling.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
    if (tx_out_valid === 1'b1 && tx_out === {1'b1, `SYM_K_SKP}) begin
      skp_n++;
      run_n++;
      if (!after_last) bad_n++;
    end else if (tx_out_valid === 1'b1) begin
      if (run_n % 2) bad_n++;
      run_n = 0;
      after_last = (tx_out.d === 8'hEE);
    end
    if (rst) begin
      have_prev = 0;
    end else if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1 && rx_out.k === 1'b0 && ts_on === 1'b0) begin
      if (have_prev) check(16'(rx_out.d), 16'(8'(rx_prev + 8'h01)));
      rx_prev = rx_out.d;
      have_prev = 1;
    end
    if (eb_over === 1'b1 || eb_under === 1'b1) over_n++;
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {training, polling_active, tseq_active, compliance_start, ping_lfps, reset_lfps} = 6'h00;
    {tx_in_valid, tx_in, rx_out_ready, link_en, after_last, ts_on} = '0;
    rx_out_ready = 1'b1;
    {n_fail, cmp_count, cyc, skp_n, run_n, bad_n, over_n, have_prev} = '0;
    rows = '{{4'b1000, 1'b1, 1'b0, `SYM_D_0_0}, {4'b0000, 1'b1, 1'b0, `SYM_D_10_2},
             {4'b0000, 1'b1, 1'b0, `SYM_D_24_3}, {4'b0000, 1'b1, 1'b1, `SYM_K_COM},
             {4'b0001, 1'b0, 9'h000}, {4'b0100, 1'b1, 1'b1, `SYM_K_287},
             {4'b0000, 1'b1, 1'b1, `SYM_K_287}, {4'b0110, 1'b0, 9'h000}, {4'b0010, 1'b0, 9'h000}};
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    link_en = 1'b1;
    // Steps through every pattern and wraps back to the first.
    for (int i = 0; i < 10; i++) begin
      ctl(i == 0 ? 4'h4 : 4'h2);
      repeat (3) @(negedge mclk);
      check(16'({tx_scramble, tx_deemph, tx_raw, tx_lfps_en}), 16'(rows[i % 9].fl));
      check(16'(tx_out_valid), 16'(!rows[i % 9].fl[0]));
      if (rows[i % 9].chk) check(16'(tx_out), 16'(rows[i % 9].s));
      check(16'(tx_in_ready), 16'h0000);
    end
    check(16'(skp_n), 16'h0000);
    ctl(4'h1);
    repeat (3) @(negedge mclk);
    check(16'({tx_scramble, tx_deemph, tx_raw, tx_lfps_en, tx_in_ready}), 16'h0001);
    $display("pattern test done");
    // Scheduling: plain, remainder carried, cleared, deferred, suppressed and saturated.
    ctl(4'h8);
    skp_n = 0;
    send(80);
    check(16'(skp_n), 16'h0006);
    send(9);
    check(16'(skp_n), 16'h0008);
    ctl(4'h8);
    skp_n = 0;
    send(20);
    ctl(4'h8);
    send(20);
    check(16'(skp_n), 16'h0000);
    training = 1'b1;
    ctl(4'h8);
    send(23);
    check(16'(skp_n), 16'h0000);
    send(22);
    check(16'(skp_n), 16'h0004);
    training = 1'b0;
    tseq_active = 1'b1;
    ctl(4'h8);
    skp_n = 0;
    send(120);
    check(16'(skp_n), 16'h0000);
    tseq_active = 1'b0;
    send(1);
    check(16'(skp_n), 16'h0008);
    check(16'(bad_n), 16'h0000);
    $display("schedule test done");
    // Receiver stalls while the partner keeps sending.
    rx_out_ready = 1'b0;
    repeat (40) @(negedge mclk);
    rx_out_ready = 1'b1;
    repeat (400) @(negedge mclk);
    check(16'(over_n), 16'h0000);
    check(16'(have_prev), 16'h0001);
    $display("receive test done");
    // Training sets with SKP sets between them keep one unbroken run.
    ts_on = 1'b1;
    repeat (1200) @(negedge mclk);
    check(16'(ts_kind), 16'h0001);
    check(16'(ts_count >= 8'h05), 16'h0001);
    $display("training set test done");
    // Reset in mid-run clears tx_out_valid, rx_out_valid, eb_over and ts_count; tx_in_ready stays high.
    rst = 1'b1;
    @(negedge mclk);
    check(16'({tx_out_valid, rx_out_valid, eb_over, ts_count, tx_in_ready}), 16'h0001);
    rst = 1'b0;
    $display("reset test done");
    report_and_stop();
  end
endmodule : skp_scheduler_elastic_compliance_bench
